// File: core/davo_outputs.sv
`timescale 1ns/10ps
`default_nettype none

module davo_outputs
  import davo_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV = SAMPLE_PERIOD_CYC,
  parameter int unsigned SAMPLE_W = 32,
  parameter int unsigned ACC_W = 50,
  parameter int unsigned DEC_W = 16
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic [DEC_W-1:0] DECIMATION,
  input wire logic [SAMPLE_W-1:0] RATE_Z,
  input wire logic [SAMPLE_W-1:0] ACCEL_X,
  input wire logic [SAMPLE_W-1:0] ACCEL_Y,
  input wire logic [SAMPLE_W-1:0] ACCEL_Z,
  input wire logic REG_RD,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  output logic [WORD_W-1:0] REG_RDATA,
  output logic REG_RVALID,
  output logic DATA_UPDATE,
  output logic SAMPLE_TICK
);

  localparam int unsigned DIV_W = (SAMPLE_DIV > 1) ? $clog2(SAMPLE_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);

  // Saturating halving of a pair-sum total to the 32-bit output format.
  function automatic logic [OUT_W-1:0] davo_sat_half(input logic [ACC_W-1:0] total);
    logic [ACC_W-1:0] half;
    logic [OUT_W-1:0] result;
    half = {total[ACC_W-1], total[ACC_W-1:1]};
    if ((&half[ACC_W-1:OUT_W-1]) || !(|half[ACC_W-1:OUT_W-1])) begin
      result = half[OUT_W-1:0];
    end else if (half[ACC_W-1]) begin
      result = SAT_NEG;
    end else begin
      result = SAT_POS;
    end
    return result;
  endfunction

  // Sample-rate divider.
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic tick;
  logic next_sample_tick;

  always_comb begin
    tick = (div_cnt == DIV_LAST);
    next_div_cnt = tick ? '0 : div_cnt + DIV_W'(1);
    next_sample_tick = tick;
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      div_cnt <= '0;
      SAMPLE_TICK <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      SAMPLE_TICK <= next_sample_tick;
    end
  end

  // Period sequencing.
  davo_state_t state;
  davo_state_t next_state;
  logic [DEC_W-1:0] smp_cnt;
  logic [DEC_W-1:0] next_smp_cnt;
  logic [DEC_W-1:0] dec_held;
  logic [DEC_W-1:0] next_dec_held;
  logic [DEC_W-1:0] dec_eff;
  logic period_start;
  logic last_sample;
  logic next_data_update;

  always_comb begin
    // The setting is caught at the first sample of a period so that a change made by
    // software mid-period never shortens or stretches the period already running.
    period_start = (smp_cnt == '0);
    dec_eff = period_start ? DECIMATION : dec_held;
    last_sample = tick && (smp_cnt == dec_eff);
    next_dec_held = (tick && period_start) ? DECIMATION : dec_held;
    next_smp_cnt = smp_cnt;
    if (tick) begin
      next_smp_cnt = last_sample ? '0 : smp_cnt + DEC_W'(1);
    end
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (tick) begin
          next_state = last_sample ? ST_PUBLISH : ST_ACCUM;
        end
      end
      ST_ACCUM: begin
        if (last_sample) begin
          next_state = ST_PUBLISH;
        end
      end
      ST_PUBLISH: begin
        next_state = last_sample ? ST_PUBLISH : ST_ACCUM;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // With a zero setting this pulses once per sample, which the host uses to
    // measure the true sample rate.
    next_data_update = (state == ST_PUBLISH);
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= ST_IDLE;
      smp_cnt <= '0;
      dec_held <= '0;
      DATA_UPDATE <= 1'b0;
    end else begin
      state <= next_state;
      smp_cnt <= next_smp_cnt;
      dec_held <= next_dec_held;
      DATA_UPDATE <= next_data_update;
    end
  end

  // Integrators: z rate for the angle, three accelerations for velocity.
  logic [SAMPLE_W-1:0] ch_sample [NUM_CH];
  logic [ACC_W-1:0] ch_acc [NUM_CH];
  logic [OUT_W-1:0] delta [NUM_CH];
  logic [OUT_W-1:0] next_delta [NUM_CH];

  always_comb begin
    ch_sample[CH_Z_ANG] = RATE_Z;
    ch_sample[CH_X_VEL] = ACCEL_X;
    ch_sample[CH_Y_VEL] = ACCEL_Y;
    ch_sample[CH_Z_VEL] = ACCEL_Z;
  end

  // Inputs arrive prescaled so that one count is one output count per sample period,
  // with the angle full scale chosen for the gyro variant; halving the pair sum then
  // gives the 1/(2fs) factor without a divider.
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      davo_trap #(
        .SAMPLE_W(SAMPLE_W),
        .ACC_W(ACC_W)
      ) u_trap (
        .clk(MCLK),
        .rst_n(RESETN),
        .sample_en(tick),
        .period_start(period_start),
        .sample_in(ch_sample[ch]),
        .acc(ch_acc[ch])
      );

      always_comb begin
        next_delta[ch] = delta[ch];
        if (state == ST_PUBLISH) begin
          next_delta[ch] = davo_sat_half(ch_acc[ch]);
        end
      end

      // One 32-bit register per axis keeps both words from the same period.
      always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
          delta[ch] <= OUT_RESET;
        end else begin
          delta[ch] <= next_delta[ch];
        end
      end
    end
  endgenerate

  // Register read port; the low address bit selects the same 16-bit register.
  logic [WORD_W-1:0] next_rdata;
  logic [ADDR_W-1:0] word_addr;

  always_comb begin
    word_addr = {REG_ADDR[ADDR_W-1:1], 1'b0};
    next_rdata = REG_RDATA;
    if (REG_RD) begin
      unique case (word_addr)
        ADDR_Z_DANG_LOW: next_rdata = delta[CH_Z_ANG][LOW_LSB +: WORD_W];
        ADDR_Z_DANG_HIGH: next_rdata = delta[CH_Z_ANG][HIGH_LSB +: WORD_W];
        ADDR_X_DVEL_LOW: next_rdata = delta[CH_X_VEL][LOW_LSB +: WORD_W];
        ADDR_X_DVEL_HIGH: next_rdata = delta[CH_X_VEL][HIGH_LSB +: WORD_W];
        ADDR_Y_DVEL_LOW: next_rdata = delta[CH_Y_VEL][LOW_LSB +: WORD_W];
        ADDR_Y_DVEL_HIGH: next_rdata = delta[CH_Y_VEL][HIGH_LSB +: WORD_W];
        ADDR_Z_DVEL_LOW: next_rdata = delta[CH_Z_VEL][LOW_LSB +: WORD_W];
        ADDR_Z_DVEL_HIGH: next_rdata = delta[CH_Z_VEL][HIGH_LSB +: WORD_W];
        default: next_rdata = RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= RDATA_RESET;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RDATA <= next_rdata;
      REG_RVALID <= REG_RD;
    end
  end

endmodule

`default_nettype wire

// File: core/davo_pkg.sv
package davo_pkg;

  // Clock and sample timing.
  localparam int unsigned CLK_FREQ_HZ = 125_000_000;
  localparam int unsigned SAMPLE_RATE_SPS = 2000;
  localparam int unsigned SAMPLE_PERIOD_CYC = CLK_FREQ_HZ / SAMPLE_RATE_SPS;

  // Register map, byte addresses on the register read port.
  localparam int unsigned ADDR_W = 7;
  localparam logic [6:0] ADDR_Z_DANG_LOW = 7'h2c;
  localparam logic [6:0] ADDR_Z_DANG_HIGH = 7'h2e;
  localparam logic [6:0] ADDR_X_DVEL_LOW = 7'h30;
  localparam logic [6:0] ADDR_X_DVEL_HIGH = 7'h32;
  localparam logic [6:0] ADDR_Y_DVEL_LOW = 7'h34;
  localparam logic [6:0] ADDR_Y_DVEL_HIGH = 7'h36;
  localparam logic [6:0] ADDR_Z_DVEL_LOW = 7'h38;
  localparam logic [6:0] ADDR_Z_DVEL_HIGH = 7'h3a;

  // Word layout of each 32-bit delta result.
  localparam int unsigned WORD_W = 16;
  localparam int unsigned OUT_W = 32;
  localparam int unsigned HIGH_LSB = 16;
  localparam int unsigned LOW_LSB = 0;

  // Values and limits.
  localparam logic [31:0] OUT_RESET = 32'h0000_0000;
  localparam logic [31:0] SAT_POS = 32'h7fff_ffff;
  localparam logic [31:0] SAT_NEG = 32'h8000_0000;
  localparam logic [15:0] RDATA_UNMAPPED = 16'h0000;
  localparam logic [15:0] RDATA_RESET = 16'h0000;

  // Channel order in the integrator array.
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned CH_Z_ANG = 0;
  localparam int unsigned CH_X_VEL = 1;
  localparam int unsigned CH_Y_VEL = 2;
  localparam int unsigned CH_Z_VEL = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCUM = 2'b01,
    ST_PUBLISH = 2'b11
  } davo_state_t;

endpackage

// File: core/davo_trap.sv
`timescale 1ns/10ps
`default_nettype none

// Trapezoidal pair-sum accumulator for one axis.
module davo_trap #(
  parameter int unsigned SAMPLE_W = 32,
  parameter int unsigned ACC_W = 50
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_en,
  input wire logic period_start,
  input wire logic [SAMPLE_W-1:0] sample_in,
  output logic [ACC_W-1:0] acc
);

  logic [SAMPLE_W-1:0] prev;
  logic [SAMPLE_W-1:0] next_prev;
  logic [ACC_W-1:0] next_acc;
  logic [ACC_W-1:0] pair_sum;

  always_comb begin
    // The previous sample carries across the period boundary, so the first pair of a
    // period uses the last sample of the period before.
    pair_sum = ACC_W'($signed(sample_in)) + ACC_W'($signed(prev));
    next_prev = prev;
    next_acc = acc;
    if (sample_en) begin
      next_prev = sample_in;
      if (period_start) begin
        next_acc = pair_sum;
      end else begin
        next_acc = acc + pair_sum;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= '0;
      acc <= '0;
    end else begin
      prev <= next_prev;
      acc <= next_acc;
    end
  end

endmodule

`default_nettype wire

// File: test/davo_outputs_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module davo_outputs_asserts
  import davo_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV = 4,
  parameter int unsigned DEC_W = 16
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic [DEC_W-1:0] DECIMATION,
  input wire logic REG_RD,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [WORD_W-1:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic DATA_UPDATE,
  input wire logic SAMPLE_TICK
);
  logic [31:0] gap, next_gap;
  logic [DEC_W:0] ticks, next_ticks;
  logic [DEC_W-1:0] dec, next_dec;
  logic [DEC_W-1:0] dec_d;
  logic seen, next_seen;
  // The setting is delayed one cycle to line up with the registered tick, so the value
  // latched is the one present at the first sample of the period, as in the design.
  always_comb begin
    next_gap = SAMPLE_TICK ? 32'h0 : gap + 32'h1;
    next_seen = seen | SAMPLE_TICK;
    next_dec = (SAMPLE_TICK && ticks == '0) ? dec_d : dec;
    next_ticks = (DATA_UPDATE ? '0 : ticks) + {{DEC_W{1'b0}}, SAMPLE_TICK};
  end
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      gap <= 32'h0;
      ticks <= '0;
      dec <= '0;
      dec_d <= '0;
      seen <= 1'b0;
    end else begin
      gap <= next_gap;
      ticks <= next_ticks;
      dec <= next_dec;
      dec_d <= DECIMATION;
      seen <= next_seen;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  property p_rd_answer; REG_RD |=> REG_RVALID; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rvalid_cause; REG_RVALID |-> $past(REG_RD); endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray rvalid");
  property p_unmapped; REG_RD && (REG_ADDR < 7'h2c || REG_ADDR > 7'h3b)
    |=> REG_RDATA == RDATA_UNMAPPED; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rdata_hold; !REG_RVALID |-> $stable(REG_RDATA); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_update_pulse; DATA_UPDATE |=> !DATA_UPDATE; endproperty
  a_update_pulse: assert property (p_update_pulse) else $error("update too long");
  property p_update_cause; DATA_UPDATE |-> $past(SAMPLE_TICK); endproperty
  a_update_cause: assert property (p_update_cause) else $error("update without tick");
  property p_period_len; DATA_UPDATE |-> ticks == {1'b0, dec} + 1'b1; endproperty
  a_period_len: assert property (p_period_len) else $error("wrong sample count");
  property p_tick_gap; SAMPLE_TICK && seen |-> gap == SAMPLE_DIV - 1; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("wrong tick spacing");
  c_update: cover property (DATA_UPDATE);
  c_sat_pos: cover property (REG_RVALID && REG_RDATA == 16'h7fff);
  c_sat_neg: cover property (REG_RVALID && REG_RDATA == 16'h8000);
  c_dec_zero: cover property (DATA_UPDATE && dec == '0);
endmodule
bind davo_outputs davo_outputs_asserts #(.SAMPLE_DIV(SAMPLE_DIV), .DEC_W(DEC_W))
  davo_outputs_asserts_i (.MCLK(MCLK), .RESETN(RESETN), .DECIMATION(DECIMATION),
  .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .DATA_UPDATE(DATA_UPDATE), .SAMPLE_TICK(SAMPLE_TICK));
`default_nettype wire

// File: test/davo_host.sv
`timescale 1ns/10ps
`default_nettype none
module davo_host
  import davo_pkg::*;
(
  input wire logic clk,
  output logic reg_rd,
  output logic [ADDR_W-1:0] reg_addr,
  input wire logic [WORD_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_rd = 1'b0;
    reg_addr = 7'h55;
  end
  // Address lines are scrambled between reads so a design that latches late shows it.
  task automatic read(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d,
                      output logic ok);
    @(posedge clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    ok = reg_rvalid;
    d = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
endmodule
`default_nettype wire

// File: test/davo_outputs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module davo_outputs_tb
  import davo_pkg::*;
;
  localparam int SMP_DIV = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] dec_set = 16'h0005;
  logic [31:0] smp [4] = '{default: 32'h0};
  logic rd, rvalid, upd, tick, ok;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] rdata, data;
  logic [31:0] e;
  logic [15:0] dec;
  logic [31:0] expq [$];
  longint acc [4] = '{default: 0};
  longint prev [4] = '{default: 0};
  int miscompares = 0, checks_done = 0, cycles = 0, mode = 0, cnt = 0, gap = 0;
  davo_outputs #(.SAMPLE_DIV(SMP_DIV)) davo_outputs_i (.MCLK(clk), .RESETN(rst_n),
    .DECIMATION(dec_set), .RATE_Z(smp[0]), .ACCEL_X(smp[1]), .ACCEL_Y(smp[2]),
    .ACCEL_Z(smp[3]), .REG_RD(rd), .REG_ADDR(addr), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .DATA_UPDATE(upd), .SAMPLE_TICK(tick));
  davo_host davo_host_i (.clk(clk), .reg_rd(rd), .reg_addr(addr), .reg_rdata(rdata),
    .reg_rvalid(rvalid));
  initial forever #4 clk = ~clk;
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // A missing update counts against the run instead of silently skewing the queue.
  task automatic wait_update();
    for (int i = 0; i < 100 && !upd; i++) @(posedge clk) #1;
    if (!upd) miscompares = miscompares + 1;
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [31:0] sat(input longint a);
    longint h;
    h = a >>> 1;
    if (h > 64'sh7fffffff) return SAT_POS;
    if (h < -64'sh80000000) return SAT_NEG;
    return h[31:0];
  endfunction
  // Modes: positive full scale, negative full scale, full-width noise, then small values.
  function automatic logic [31:0] pick();
    logic [31:0] r;
    r = $urandom;
    case (mode)
      0: pick = 32'h7fffffff;
      1: pick = 32'h80000000;
      2: pick = r;
      default: pick = {{8{r[23]}}, r[23:0]};
    endcase
  endfunction
  // Inputs only move just after a tick, so they are steady at the next sampling edge.
  always @(posedge clk) begin
    #1;
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
    if (tick) begin
      if (cnt == 0) dec = dec_set;
      for (int c = 0; c < 4; c++) begin
        acc[c] = acc[c] + $signed(smp[c]) + prev[c];
        prev[c] = $signed(smp[c]);
        smp[c] = pick();
      end
      cnt = cnt + 1;
      if (cnt == dec + 1) begin
        for (int c = 0; c < 4; c++) begin
          expq.push_back(sat(acc[c]));
          acc[c] = 0;
        end
        cnt = 0;
      end
    end
  end
  initial begin
    void'($urandom(47863));
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    davo_host_i.read(ADDR_X_DVEL_HIGH, data, ok);
    check({ok, data}, {1'b1, RDATA_RESET});
    for (int p = 0; p < 12; p++) begin
      wait_update();
      mode = (p < 3) ? p + 1 : 3;
      dec_set = 16'(5 + $urandom_range(2));
      for (int c = 0; c < 4; c++) begin
        e = expq.pop_front();
        davo_host_i.read(ADDR_Z_DANG_LOW + 7'(4 * c), data, ok);
        check({ok, data}, {1'b1, e[15:0]});
        davo_host_i.read(ADDR_Z_DANG_HIGH + 7'(4 * c), data, ok);
        check({ok, data}, {1'b1, e[31:16]});
      end
      davo_host_i.read(7'h40, data, ok);
      check({ok, data}, {1'b1, RDATA_UNMAPPED});
    end
    // Decimation zero: updates then follow the sample rate, which the host can time.
    wait_update();
    dec_set = 16'h0000;
    @(posedge clk) #1;
    wait_update();
    @(posedge clk) #1;
    gap = 1;
    while (!upd && gap < 100) begin
      @(posedge clk) #1;
      gap = gap + 1;
    end
    check(17'(gap), 17'(SMP_DIV));
    e = expq[expq.size() - 3];
    davo_host_i.read(ADDR_X_DVEL_LOW, data, ok);
    check({ok, data}, {1'b1, e[15:0]});
    report_and_stop();
  end
endmodule
`default_nettype wire
